/* File: hw/spp_pkg.sv */
// Constants and types shared by the serial port and its bench
package spp_pkg;

  // Mode codes held in the two-bit mode field
  localparam logic [1:0] MODE_SYNC    = 2'h0;
  localparam logic [1:0] MODE_UART8   = 2'h1;
  localparam logic [1:0] MODE_FIXED9  = 2'h2;
  localparam logic [1:0] MODE_VAR9    = 2'h3;

  // Baud source select codes, timers 1 to 4
  localparam logic [1:0] SEL_TIMER1   = 2'h0;
  localparam logic [1:0] SEL_TIMER2   = 2'h1;
  localparam logic [1:0] SEL_TIMER3   = 2'h2;
  localparam logic [1:0] SEL_TIMER4   = 2'h3;

  // Core clock rate
  localparam int         CLOCK_MHZ    = 100;

  // Synchronous mode: twelve core clocks per bit
  localparam logic [3:0] SYNC_LAST    = 4'hB;
  localparam logic [3:0] SYNC_PRE_RISE = 4'h5;
  localparam logic [3:0] SYNC_RISE    = 4'h6;

  // Asynchronous modes: sixteen sub-ticks per bit
  localparam logic [3:0] OS_LAST      = 4'hF;
  localparam logic [3:0] OS_MID       = 4'h7;

  // Sub-tick prescale: 64/16, 32/16, timer 1 32/16, and 16/16
  localparam logic [2:0] DIV_FIXED_SLOW = 3'h4;
  localparam logic [2:0] DIV_FIXED_FAST = 3'h2;
  localparam logic [2:0] DIV_T1_SLOW    = 3'h2;
  localparam logic [2:0] DIV_NONE       = 3'h1;

  // Bits per frame, and counts of bits left
  localparam logic [3:0] BITS_SYNC    = 4'h8;
  localparam logic [3:0] BITS_UART8   = 4'hA;
  localparam logic [3:0] BITS_UART9   = 4'hB;
  localparam logic [3:0] BITS_STOP    = 4'h2;
  localparam logic [3:0] BITS_ONE     = 4'h1;

  // Reset values
  localparam logic       TX_LINE_IDLE = 1'b1;
  localparam logic [7:0] RX_BUF_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ASYNC,
    ST_SYNC,
    ST_SYNC_FIN
  } spp_tx_state_type;

  typedef enum logic {
    ARX_IDLE,
    ARX_RUN
  } spp_rx_state_type;

endpackage : spp_pkg

/* File: hw/spp_serial_port.sv */
// Serial port with synchronous and asynchronous modes
`timescale 1ns/100ps

module spp_serial_port #(
  parameter int DATA_W    = 8,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  // Control bits
  input  wire logic [1:0]        MODE,
  input  wire logic              RX_ENABLE_BIT,
  input  wire logic              MULTIPROC_MODE_BIT,
  input  wire logic              BAUD_DOUBLE_BIT,
  input  wire logic              TX_NINTH_BIT,
  input  wire logic [1:0]        TX_BAUD_SEL,
  input  wire logic [1:0]        RX_BAUD_SEL,
  input  wire logic              INT_ENABLE,
  input  wire logic [7:0]        SLAVE_ADDR,
  input  wire logic [7:0]        ADDR_MASK,
  // Done flags and interrupt
  input  wire logic              TX_DONE_CLEAR,
  input  wire logic              RX_DONE_CLEAR,
  output logic                   TX_DONE_FLAG,
  output logic                   RX_DONE_FLAG,
  output logic                   INT_REQ,
  // Timer 1 to 4 overflow pulses
  input  wire logic [3:0]        TIMER_OVERFLOW,
  // Serial buffer, write and read sides
  input  wire logic              TX_WR_VALID,
  input  wire logic [DATA_W-1:0] TX_WR_DATA,
  output logic                   TX_WR_READY,
  output logic [7:0]             RX_BUFFER,
  output logic                   RX_NINTH_BIT,
  // Pins
  input  wire logic              SERIAL_RX_PIN_IN,
  output logic                   SERIAL_RX_PIN_OUT,
  output logic                   SERIAL_RX_PIN_OE,
  output logic                   SERIAL_TX_PIN
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  // Prescale from source pulses to sixteen sub-ticks per bit
  function automatic logic [2:0] tick_div(input logic [1:0] mode,
                                          input logic       dbl,
                                          input logic [1:0] sel);
    if (mode == spp_pkg::MODE_FIXED9) begin
      tick_div = dbl ? spp_pkg::DIV_FIXED_FAST : spp_pkg::DIV_FIXED_SLOW;
    end else if (sel == spp_pkg::SEL_TIMER1 && !dbl) begin
      tick_div = spp_pkg::DIV_T1_SLOW;
    end else begin
      tick_div = spp_pkg::DIV_NONE;
    end
  endfunction : tick_div

  function automatic logic tick_src(input logic [1:0] mode,
                                    input logic [1:0] sel,
                                    input logic [3:0] ovf);
    // Fixed mode counts core clocks, the others timer rollovers
    if (mode == spp_pkg::MODE_FIXED9) begin
      tick_src = 1'b1;
    end else begin
      tick_src = ovf[sel];
    end
  endfunction : tick_src

  // Pointers wrap at the depth, which need not be a power of two
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(BUF_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  // Transmit buffer
  // Two entries let software queue two bytes while one is on the line
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]  wr_ptr;
  logic [PTR_W-1:0]  rd_ptr;
  logic [PTR_W:0]    buf_count;

  // Baud prescalers
  logic [2:0]        tx_pre;
  logic [2:0]        rx_pre;

  // Transmit and synchronous engine
  spp_pkg::spp_tx_state_type tx_state;
  logic [10:0]       tx_shift;
  logic [3:0]        tx_left;
  logic [3:0]        tx_os;
  logic [3:0]        sy_cnt;
  logic              sy_rx;

  // Asynchronous receiver
  spp_pkg::spp_rx_state_type rx_state;
  logic [10:0]       rx_shift;
  logic [3:0]        rx_left;
  logic [3:0]        rx_os;
  logic              rx_pin_last;

  // Decoding
  wire               is_sync     = MODE == spp_pkg::MODE_SYNC;
  wire               is_uart8    = MODE == spp_pkg::MODE_UART8;
  wire [3:0]         frame_bits  = is_uart8 ? spp_pkg::BITS_UART8
                                            : spp_pkg::BITS_UART9;
  wire               buf_valid   = buf_count != '0;
  wire               buf_push    = TX_WR_VALID && TX_WR_READY;
  wire               buf_pop     = tx_state == spp_pkg::ST_IDLE && buf_valid;
  wire [DATA_W-1:0]  buf_head    = buf_mem[rd_ptr];
  wire [PTR_W:0]     next_count  = buf_count + {{PTR_W{1'b0}}, buf_push}
                                             - {{PTR_W{1'b0}}, buf_pop};

  wire               tx_src      = tick_src(MODE, TX_BAUD_SEL, TIMER_OVERFLOW);
  wire               rx_src      = tick_src(MODE, RX_BAUD_SEL, TIMER_OVERFLOW);
  wire [2:0]         tx_div      = tick_div(MODE, BAUD_DOUBLE_BIT,
                                            TX_BAUD_SEL);
  wire [2:0]         rx_div      = tick_div(MODE, BAUD_DOUBLE_BIT,
                                            RX_BAUD_SEL);
  wire               tx_tick     = tx_src && tx_pre == tx_div - 3'h1;
  wire               rx_tick     = rx_src && rx_pre == rx_div - 3'h1;

  wire               async_end   = tx_state == spp_pkg::ST_ASYNC && tx_tick
                                   && tx_os == spp_pkg::OS_LAST;
  wire               sync_end    = tx_state == spp_pkg::ST_SYNC
                                   && sy_cnt == spp_pkg::SYNC_LAST;
  wire               sync_start  = tx_state == spp_pkg::ST_IDLE && is_sync
                                   && !buf_valid && RX_ENABLE_BIT
                                   && !RX_DONE_FLAG;
  wire               tx_done_set = (async_end && tx_left == spp_pkg::BITS_STOP)
                                   || (sync_end && !sy_rx
                                   && tx_left == spp_pkg::BITS_ONE);

  wire [10:0]        rx_frame    = {SERIAL_RX_PIN_IN, rx_shift[10:1]};
  // A level start would retrigger on a low stop bit; wait for a fall
  wire               rx_start    = !is_sync && RX_ENABLE_BIT && rx_pin_last
                                   && !SERIAL_RX_PIN_IN;
  wire               rx_sample   = rx_state == spp_pkg::ARX_RUN && rx_tick
                                   && rx_os == spp_pkg::OS_MID;
  wire               rx_false    = rx_sample && rx_left == frame_bits
                                   && SERIAL_RX_PIN_IN;
  wire               rx_last     = rx_sample && rx_left == spp_pkg::BITS_ONE;
  wire [7:0]         rx_data     = is_uart8 ? rx_frame[9:2] : rx_frame[8:1];
  // Mode 1 keeps the stop bit as ninth, the 9-bit modes skip the stop bit
  wire               rx_ninth    = is_uart8 ? rx_frame[10] : rx_frame[9];
  wire               addr_match  = ((rx_data ^ SLAVE_ADDR) & ADDR_MASK) == 8'h00;
  wire               rx_accept   = rx_last && !RX_DONE_FLAG
                                   && (!MULTIPROC_MODE_BIT
                                   || (rx_ninth && (is_uart8 || addr_match)));
  wire               sync_rx_set = tx_state == spp_pkg::ST_SYNC_FIN;
  wire               rx_done_set = rx_accept || sync_rx_set;

  // Set wins over a clear in the same cycle
  wire               next_tx_done = tx_done_set
                                    || (TX_DONE_FLAG && !TX_DONE_CLEAR);
  wire               next_rx_done = rx_done_set
                                    || (RX_DONE_FLAG && !RX_DONE_CLEAR);

  // Buffer storage needs no reset; occupancy does
  always_ff @(posedge CLOCK) begin
    if (buf_push) begin
      buf_mem[wr_ptr] <= TX_WR_DATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      buf_count   <= '0;
      TX_WR_READY <= 1'b0;
    end else begin
      if (buf_push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (buf_pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      buf_count   <= next_count;
      TX_WR_READY <= next_count != (PTR_W + 1)'(BUF_DEPTH);
    end
  end

  // Prescalers turn source pulses into sixteenth-of-bit ticks
  // They free-run, so a first bit may end up to one step early
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tx_pre <= 3'h0;
      rx_pre <= 3'h0;
    end else begin
      if (tx_src) begin
        tx_pre <= tx_tick ? 3'h0 : tx_pre + 3'h1;
      end
      if (rx_src) begin
        rx_pre <= rx_tick ? 3'h0 : rx_pre + 3'h1;
      end
    end
  end

  // Transmit engine, also runs the half-duplex synchronous mode
  // Mode and rate inputs are read live; change them only between frames
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tx_state          <= spp_pkg::ST_IDLE;
      tx_shift          <= 11'h7FF;
      tx_left           <= 4'h0;
      tx_os             <= 4'h0;
      sy_cnt            <= 4'h0;
      sy_rx             <= 1'b0;
      SERIAL_TX_PIN     <= spp_pkg::TX_LINE_IDLE;
      SERIAL_RX_PIN_OE  <= 1'b0;
    end else begin
      case (tx_state)
        spp_pkg::ST_IDLE: begin
          tx_os  <= 4'h0;
          sy_cnt <= 4'h0;
          if (buf_pop && is_sync) begin
            tx_state         <= spp_pkg::ST_SYNC;
            tx_shift         <= {3'h7, buf_head[7:0]};
            tx_left          <= spp_pkg::BITS_SYNC;
            sy_rx            <= 1'b0;
            SERIAL_RX_PIN_OE <= !buf_head[0];
            SERIAL_TX_PIN    <= 1'b0;
          end else if (buf_pop) begin
            tx_state      <= spp_pkg::ST_ASYNC;
            tx_shift      <= {1'b1, is_uart8 ? 1'b1 : TX_NINTH_BIT,
                              buf_head[7:0], 1'b0};
            tx_left       <= frame_bits;
            SERIAL_TX_PIN <= 1'b0;
          end else if (sync_start) begin
            tx_state      <= spp_pkg::ST_SYNC;
            tx_left       <= spp_pkg::BITS_SYNC;
            sy_rx         <= 1'b1;
            SERIAL_TX_PIN <= 1'b0;
          end
        end
        spp_pkg::ST_ASYNC: begin
          if (tx_tick) begin
            tx_os <= tx_os + 4'h1;
          end
          if (async_end) begin
            tx_shift      <= {1'b1, tx_shift[10:1]};
            tx_left       <= tx_left - 4'h1;
            SERIAL_TX_PIN <= tx_shift[1];
            if (tx_left == spp_pkg::BITS_ONE) begin
              tx_state      <= spp_pkg::ST_IDLE;
              SERIAL_TX_PIN <= spp_pkg::TX_LINE_IDLE;
            end
          end
        end
        spp_pkg::ST_SYNC: begin
          sy_cnt        <= sync_end ? 4'h0 : sy_cnt + 4'h1;
          // Clock high for the second half of each bit
          SERIAL_TX_PIN <= sy_cnt >= spp_pkg::SYNC_PRE_RISE && !sync_end;
          // Receive samples on the first high clock cycle
          if (sy_rx && sy_cnt == spp_pkg::SYNC_RISE) begin
            tx_shift[7:0] <= {SERIAL_RX_PIN_IN, tx_shift[7:1]};
          end
          if (sync_end && !sy_rx) begin
            tx_shift         <= {1'b1, tx_shift[10:1]};
            SERIAL_RX_PIN_OE <= !tx_shift[1]
                                && tx_left != spp_pkg::BITS_ONE;
          end
          if (sync_end) begin
            tx_left <= tx_left - 4'h1;
            if (tx_left == spp_pkg::BITS_ONE) begin
              tx_state      <= sy_rx ? spp_pkg::ST_SYNC_FIN
                                     : spp_pkg::ST_IDLE;
              SERIAL_TX_PIN <= spp_pkg::TX_LINE_IDLE;
            end
          end
        end
        spp_pkg::ST_SYNC_FIN: begin
          tx_state <= spp_pkg::ST_IDLE;
        end
        default: begin
          tx_state <= spp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Asynchronous receiver; a glitch shorter than half a bit is dropped
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rx_state <= spp_pkg::ARX_IDLE;
      rx_shift <= 11'h000;
      rx_left  <= 4'h0;
      rx_os    <= 4'h0;
      // Idle line level, so reset leaves no false falling edge
      rx_pin_last <= 1'b1;
    end else begin
      rx_pin_last <= SERIAL_RX_PIN_IN;
      case (rx_state)
        spp_pkg::ARX_IDLE: begin
          rx_os <= 4'h0;
          if (rx_start) begin
            rx_state <= spp_pkg::ARX_RUN;
            rx_left  <= frame_bits;
          end
        end
        spp_pkg::ARX_RUN: begin
          if (rx_tick) begin
            rx_os <= rx_os + 4'h1;
          end
          if (rx_sample) begin
            rx_shift <= rx_frame;
            rx_left  <= rx_left - 4'h1;
          end
          if (rx_false || rx_last || is_sync || !RX_ENABLE_BIT) begin
            rx_state <= spp_pkg::ARX_IDLE;
          end
        end
        default: begin
          rx_state <= spp_pkg::ARX_IDLE;
        end
      endcase
    end
  end

  // Receive holding register, flags and interrupt
  // Interrupt follows the next flag values, so it rises with them
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      RX_BUFFER         <= spp_pkg::RX_BUF_RESET;
      RX_NINTH_BIT      <= 1'b0;
      TX_DONE_FLAG      <= 1'b0;
      RX_DONE_FLAG      <= 1'b0;
      INT_REQ           <= 1'b0;
      SERIAL_RX_PIN_OUT <= 1'b0;
    end else begin
      if (rx_accept) begin
        RX_BUFFER    <= rx_data;
        RX_NINTH_BIT <= rx_ninth;
      end else if (sync_rx_set) begin
        RX_BUFFER <= tx_shift[7:0];
      end
      TX_DONE_FLAG      <= next_tx_done;
      RX_DONE_FLAG      <= next_rx_done;
      INT_REQ           <= INT_ENABLE && (next_tx_done || next_rx_done);
      // Open drain: only a low level is ever driven
      SERIAL_RX_PIN_OUT <= 1'b0;
    end
  end

endmodule : spp_serial_port

/* File: dv/spp_serial_port_props.sv */
// Checker for the serial port pins and flags
`timescale 1ns/100ps
module spp_serial_port_props (
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RST_N,
  // Watched ports
  input wire logic [1:0] MODE,
  input wire logic       INT_ENABLE,
  input wire logic       TX_DONE_CLEAR,
  input wire logic       RX_DONE_CLEAR,
  input wire logic       TX_DONE_FLAG,
  input wire logic       RX_DONE_FLAG,
  input wire logic       INT_REQ,
  input wire logic [7:0] RX_BUFFER,
  input wire logic       SERIAL_RX_PIN_OUT,
  input wire logic       SERIAL_RX_PIN_OE,
  input wire logic       SERIAL_TX_PIN
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire logic any_flag = TX_DONE_FLAG | RX_DONE_FLAG;
  wire logic sync = MODE == spp_pkg::MODE_SYNC;
  property p_int_on;
    any_flag && INT_ENABLE && $past(INT_ENABLE) |-> INT_REQ;
  endproperty
  a_int_on: assert property (p_int_on) else $error("irq missing");
  property p_int_off;
    !any_flag || (!INT_ENABLE && !$past(INT_ENABLE)) |-> !INT_REQ;
  endproperty
  a_int_off: assert property (p_int_off) else $error("irq stray");
  property p_tx_keep;
    $past(TX_DONE_FLAG) && !$past(TX_DONE_CLEAR) |-> TX_DONE_FLAG;
  endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("tx flag lost");
  property p_rx_keep;
    $past(RX_DONE_FLAG) && !$past(RX_DONE_CLEAR) |-> RX_DONE_FLAG;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx flag lost");
  property p_od;
    SERIAL_RX_PIN_OE |-> !SERIAL_RX_PIN_OUT && sync;
  endproperty
  a_od: assert property (p_od) else $error("rx pin drive");
  property p_clk_low;
    sync && $fell(SERIAL_TX_PIN) |-> !SERIAL_TX_PIN [*6] ##1 SERIAL_TX_PIN;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock low");
  property p_clk_high;
    sync && $rose(SERIAL_TX_PIN) |-> SERIAL_TX_PIN [*6];
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high");
  property p_rx_hold;
    !sync && !$stable(RX_BUFFER) |-> $rose(RX_DONE_FLAG);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx load");
  property p_stop;
    !sync && $rose(TX_DONE_FLAG) |-> ##1 SERIAL_TX_PIN [*8];
  endproperty
  a_stop: assert property (p_stop) else $error("tx flag time");
  c_sync: cover property (sync && $fell(SERIAL_TX_PIN));
  c_rx: cover property ($rose(RX_DONE_FLAG));
  c_int: cover property (INT_REQ);
endmodule : spp_serial_port_props

bind spp_serial_port spp_serial_port_props spp_serial_port_props_i (
  .CLOCK, .RST_N, .MODE, .INT_ENABLE, .TX_DONE_CLEAR, .RX_DONE_CLEAR,
  .TX_DONE_FLAG, .RX_DONE_FLAG, .INT_REQ, .RX_BUFFER,
  .SERIAL_RX_PIN_OUT, .SERIAL_RX_PIN_OE, .SERIAL_TX_PIN);

/* File: dv/spp_remote_node.sv */
// Remote node: async framer and mode 0 shift peripheral
`timescale 1ns/100ps
module spp_remote_node (
  // Clock
  input  wire logic clock,
  // Device pins
  input  wire logic tx_pin,
  input  wire logic rx_out,
  input  wire logic rx_oe,
  output wire logic rx_line
);
  logic drv = 1'h1;
  // Pull-up holds the line high once released
  assign rx_line = rx_oe ? rx_out : drv;
  // Start bit lands in v[0]; mid-bit samples
  task automatic get(input int bt, input int n, output logic [10:0] v);
    v = 11'h000;
    @(negedge tx_pin);
    repeat (bt / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      v[i] = tx_pin;
      if (i < n - 1) repeat (bt) @(posedge clock);
    end
  endtask : get
  // Called at a falling clock edge
  task automatic put(input int bt, input int n, input logic [10:0] v);
    for (int i = 0; i < n; i++) begin
      drv = v[i];
      repeat (bt) @(negedge clock);
    end
    drv = 1'h1;
  endtask : put
  task automatic grab(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_pin);
      v[i] = rx_line;
    end
  endtask : grab
  // Data held well past the sampling cycle
  task automatic feed(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      drv = v[i];
      @(posedge tx_pin);
      repeat (3) @(negedge clock);
    end
    drv = 1'h1;
  endtask : feed
endmodule : spp_remote_node

/* File: dv/spp_serial_port_bench.sv */
// Self-checking bench for the serial port
`timescale 1ns/100ps
module spp_serial_port_bench;
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic [1:0] mode = spp_pkg::MODE_FIXED9;
  logic [1:0] tsel = spp_pkg::SEL_TIMER1;
  logic [1:0] rsel = spp_pkg::SEL_TIMER1;
  logic [3:0] ovf = 4'h0;
  logic [7:0] wd = 8'h00;
  logic       rxen = 1'h0, mp = 1'h0, dbl = 1'h0, ninth = 1'h0;
  logic       inten = 1'h1, tclr = 1'h0, rclr = 1'h0, wv = 1'h0;
  wire logic  tdone, rdone, irq, wrdy, rx9, rx_out, rx_oe, tx_pin, rx_line;
  wire logic [7:0] rbuf;
  logic [10:0] got;
  logic [7:0]  gb;
  int error_cnt = 0, checked = 0, cyc = 0;
  spp_serial_port spp_serial_port_i (.CLOCK(clk), .RST_N(rst_n),
    .MODE(mode), .RX_ENABLE_BIT(rxen), .MULTIPROC_MODE_BIT(mp),
    .BAUD_DOUBLE_BIT(dbl), .TX_NINTH_BIT(ninth), .TX_BAUD_SEL(tsel),
    .RX_BAUD_SEL(rsel), .INT_ENABLE(inten), .SLAVE_ADDR(8'h35),
    .ADDR_MASK(8'h0F), .TX_DONE_CLEAR(tclr), .RX_DONE_CLEAR(rclr),
    .TX_DONE_FLAG(tdone), .RX_DONE_FLAG(rdone), .INT_REQ(irq),
    .TIMER_OVERFLOW(ovf), .TX_WR_VALID(wv), .TX_WR_DATA(wd),
    .TX_WR_READY(wrdy), .RX_BUFFER(rbuf), .RX_NINTH_BIT(rx9),
    .SERIAL_RX_PIN_IN(rx_line), .SERIAL_RX_PIN_OUT(rx_out),
    .SERIAL_RX_PIN_OE(rx_oe), .SERIAL_TX_PIN(tx_pin));
  spp_remote_node spp_remote_node_i (.clock(clk), .tx_pin(tx_pin),
    .rx_out(rx_out), .rx_oe(rx_oe), .rx_line(rx_line));
  always #5 clk = ~clk;
  // Timers 1 to 4 roll over every 2, 4, 6 and 8 cycles
  always @(negedge clk) begin
    ovf <= {cyc % 8 == 0, cyc % 6 == 0, cyc % 4 == 0, cyc % 2 == 0};
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end
  // Cycles per bit from the mode, timer period and doubling
  function automatic int abit(input logic [1:0] s);
    if (mode == spp_pkg::MODE_FIXED9) return dbl ? 32 : 64;
    if (s == spp_pkg::SEL_TIMER1 && !dbl) return 64;
    return (int'(s) + 1) * 32;
  endfunction : abit
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d);
    @(negedge clk);
    wv = 1'h1;
    wd = d;
    while (wrdy !== 1'h1) @(negedge clk);
    @(negedge clk);
    wv = 1'h0;
  endtask : wr
  task automatic clr;
    @(negedge clk);
    tclr = 1'h1;
    rclr = 1'h1;
    @(negedge clk);
    tclr = 1'h0;
    rclr = 1'h0;
  endtask : clr
  task automatic send(input logic [7:0] d);
    int n;
    n = (mode == spp_pkg::MODE_UART8) ? 10 : 11;
    clr();
    wr(d);
    chk(tdone, 1'h0);
    spp_remote_node_i.get(abit(tsel), n, got);
    chk(got, (n == 10) ? {2'h1, d, 1'h0} : {1'h1, ninth, d, 1'h0});
    chk(tdone, 1'h1);
    chk(irq, inten);
    // Let the stop bit finish before the caller changes mode or rate
    repeat (abit(tsel)) @(negedge clk);
  endtask : send
  task automatic recv(input logic [10:0] v, input logic ok);
    logic       f0;
    logic [8:0] old;
    f0 = rdone;
    old = {rx9, rbuf};
    spp_remote_node_i.put(abit(rsel),
      (mode == spp_pkg::MODE_UART8) ? 10 : 11, v);
    repeat (4) @(negedge clk);
    chk(rdone, ok | f0);
    chk({rx9, rbuf}, ok ? v[9:1] : old);
  endtask : recv
  task automatic results;
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk({tdone, rdone, irq, tx_pin, rx_oe, wrdy, rbuf},
      {3'h0, spp_pkg::TX_LINE_IDLE, 2'h1, spp_pkg::RX_BUF_RESET});
    for (int i = 0; i < 2; i++) begin
      dbl = i[0];
      ninth = ~i[0];
      send(8'hA5 ^ i[7:0]);
    end
    mode = spp_pkg::MODE_VAR9;
    tsel = spp_pkg::SEL_TIMER2;
    send(8'h3C);
    mode = spp_pkg::MODE_UART8;
    // Timers 1 to 4 with doubling, then timer 1 without
    for (int s = 0; s < 5; s++) begin
      tsel = s[1:0];
      dbl = s < 4;
      send(8'h81 + s[7:0]);
    end
    inten = 1'h0;
    repeat (2) @(negedge clk);
    chk(irq, 1'h0);
    inten = 1'h1;
    // Fill the buffer until it refuses, then drain
    mode = spp_pkg::MODE_FIXED9;
    dbl = 1'h1;
    fork
      begin
        wr(8'h11);
        wr(8'h22);
        wr(8'h33);
        @(negedge clk);
        chk(wrdy, 1'h0);
        wr(8'h44);
      end
      for (int k = 1; k < 5; k++) begin
        spp_remote_node_i.get(32, 11, got);
        chk(got, {1'h1, ninth, 4'(k), 4'(k), 1'h0});
      end
    join
    repeat (32) @(negedge clk);
    chk(wrdy, 1'h1);
    dbl = 1'h0;
    rxen = 1'h1;
    clr();
    recv({2'h3, 8'h5A, 1'h0}, 1'h1);
    recv({2'h2, 8'h77, 1'h0}, 1'h0);
    clr();
    mp = 1'h1;
    recv({2'h2, 8'hA5, 1'h0}, 1'h0);
    recv({2'h3, 8'hA6, 1'h0}, 1'h0);
    recv({2'h3, 8'hA5, 1'h0}, 1'h1);
    mode = spp_pkg::MODE_UART8;
    rsel = spp_pkg::SEL_TIMER3;
    clr();
    recv({2'h0, 8'hC3, 1'h0}, 1'h0);
    recv({2'h1, 8'hC3, 1'h0}, 1'h1);
    rxen = 1'h0;
    mp = 1'h0;
    mode = spp_pkg::MODE_SYNC;
    clr();
    fork
      wr(8'h96);
      spp_remote_node_i.grab(gb);
    join
    repeat (12) @(negedge clk);
    chk(gb, 8'h96);
    chk(tdone, 1'h1);
    clr();
    rxen = 1'h1;
    spp_remote_node_i.feed(8'h4B);
    for (int i = 0; i < 100 && rdone !== 1'h1; i++) @(negedge clk);
    chk({rdone, rbuf}, {1'h1, 8'h4B});
    results();
  end
endmodule : spp_serial_port_bench
